// File: core/ebc_ctrl.v
/*
  external bus controller: decodes four prioritised windows plus default,
  runs muxed or demuxed bus cycles, ready handshake, hold arbitration.
  assumes cpu requests are held stable until o_cpu_done; pins are
  synchronous to i_clock; one i_clock cycle is half a cpu clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.vh"

module ebc_ctrl #(
  parameter AW = 24,
  parameter NWIN = 4
) (
  // clock and reset
  input wire i_clock,
  input wire i_nrst,
  // cpu side request
  input wire i_cpu_req,
  input wire i_cpu_write,
  input wire i_cpu_byte,
  input wire [AW-1:0] i_cpu_addr,
  input wire [15:0] i_cpu_wdata,
  output reg o_cpu_done,
  output reg [15:0] o_cpu_rdata,
  // configuration
  input wire [NWIN*`EBC_SEL_W-1:0] i_window_select_reg,
  input wire [NWIN*`EBC_CFG_W-1:0] i_window_bus_config_reg,
  input wire [`EBC_CFG_W-1:0] i_default_bus_config_reg,
  input wire i_early_chip_select_bit,
  input wire i_arbitration_enable_bit,
  input wire i_arbiter_slave_select_bit,
  // status
  output reg [`EBC_SYSCFG_W-1:0] o_system_config_reg,
  output reg o_illegal_bus_access_flag,
  output reg o_class_b_trap,
  input wire i_trap_flag_clear,
  // shared address/data port
  input wire [15:0] i_shared_addr_data_port,
  output reg [15:0] o_shared_addr_data_port,
  output reg [15:0] o_shared_addr_data_oe,
  // address ports
  output reg [15:0] o_demux_address_port,
  output reg [7:0] o_upper_address_port,
  // strobes and selects
  output reg o_ale,
  output reg o_read_strobe_n,
  output reg o_write_strobe_n,
  output reg o_write_high_strobe_n,
  output reg [NWIN-1:0] o_window_chip_select_n,
  output reg o_default_chip_select_n,
  input wire i_ready,
  // arbitration pins
  input wire i_hold_request_n,
  output reg o_bus_request_out_n,
  input wire i_hold_acknowledge_n,
  output reg o_hold_acknowledge_n,
  output reg o_hold_acknowledge_oe
);
  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DLY = 3'h2;
  localparam ST_CMD = 3'h3;
  localparam ST_TRI = 3'h4;
  localparam ST_HOLD = 3'h5;

  // ---------------------------------------------------------------
  // window decode
  // ---------------------------------------------------------------
  wire [NWIN-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < NWIN; g = g + 1) begin : gen_win
      ebc_window #(.AW(AW)) u_win (
        .i_addr(i_cpu_addr),
        .i_select(i_window_select_reg[g*`EBC_SEL_W +: `EBC_SEL_W]),
        .i_enable(i_window_bus_config_reg[g*`EBC_CFG_W+`EBC_CFG_ACTIVE_BIT]),
        .o_hit(hit[g])
      );
    end
  endgenerate

  reg [NWIN:0] sel_onehot;
  reg [`EBC_CFG_W-1:0] sel_cfg;
  always @* begin
    // higher pair overrides lower: 4 over 3, 2 over 1
    sel_onehot = {(NWIN+1){1'b0}};
    sel_cfg = i_default_bus_config_reg;
    if (hit[3]) begin
      sel_onehot[3] = 1'b1;
      sel_cfg = i_window_bus_config_reg[3*`EBC_CFG_W +: `EBC_CFG_W];
    end else if (hit[2]) begin
      sel_onehot[2] = 1'b1;
      sel_cfg = i_window_bus_config_reg[2*`EBC_CFG_W +: `EBC_CFG_W];
    end else if (hit[1]) begin
      sel_onehot[1] = 1'b1;
      sel_cfg = i_window_bus_config_reg[1*`EBC_CFG_W +: `EBC_CFG_W];
    end else if (hit[0]) begin
      sel_onehot[0] = 1'b1;
      sel_cfg = i_window_bus_config_reg[0 +: `EBC_CFG_W];
    end else begin
      sel_onehot[NWIN] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // cycle registers
  // ---------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [`EBC_CFG_W-1:0] cfg_reg;
  reg [NWIN:0] region_reg;
  reg [3:0] wait_reg;
  reg [7:0] tmo_reg;
  reg write_reg;
  reg byte_reg;
  reg [AW-1:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [1:0] sub_reg;
  reg init_reg;

  wire [1:0] mode = cfg_reg[`EBC_MODE_LSB +: `EBC_MODE_W];
  wire muxed = mode[0];
  wire wide = mode[1];
  wire rdy_en = cfg_reg[`EBC_CFG_RDYEN_BIT];
  wire rdy_ok = (i_ready == cfg_reg[`EBC_CFG_RDYLVL_BIT]);
  wire ext_on = o_system_config_reg[`EBC_SYSCFG_EXT_BIT];
  wire [1:0] space = o_system_config_reg[`EBC_SYSCFG_SPACE_LSB +: 2];
  wire slave = i_arbiter_slave_select_bit;
  wire hold_in = i_arbitration_enable_bit & ~i_hold_request_n;
  wire slave_granted = ~i_hold_acknowledge_n;
  wire can_start = ~slave | slave_granted;
  wire sel_cs_en = sel_cfg[`EBC_CFG_CSEN_BIT];

  // ---------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------
  wire wait_done = (wait_reg == 4'h0);
  wire tmo = (tmo_reg == `EBC_READY_TIMEOUT);
  // a trap event in this cycle, so that a clear in the same cycle loses
  wire trap_set = ((state_reg == ST_IDLE) &&
    (state_next == ST_ADDR) && !ext_on) ||
    ((state_reg == ST_CMD) && (state_next != ST_CMD) && tmo);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (hold_in && !slave)
          state_next = ST_HOLD;
        else if (i_cpu_req && !o_cpu_done && can_start)
          state_next = ST_ADDR;
      end
      ST_ADDR: begin
        // latch strobe spans one or two sub-cycles
        if (sub_reg == {1'b0, cfg_reg[`EBC_CFG_ALE_BIT]})
          state_next = cfg_reg[`EBC_CFG_RWDLY_BIT] ? ST_DLY : ST_CMD;
      end
      ST_DLY: state_next = ST_CMD;
      ST_CMD: begin
        if ((wait_done && (!rdy_en || rdy_ok)) || tmo)
          state_next = cfg_reg[`EBC_CFG_TRI_BIT] ? ST_TRI : ST_IDLE;
      end
      ST_TRI: state_next = ST_IDLE;
      ST_HOLD: begin
        if (!hold_in)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // sequential part
  // ---------------------------------------------------------------
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      cfg_reg <= {`EBC_CFG_W{1'b0}};
      region_reg <= {(NWIN+1){1'b0}};
      wait_reg <= 4'h0;
      tmo_reg <= 8'h00;
      write_reg <= 1'b0;
      byte_reg <= 1'b0;
      addr_reg <= {AW{1'b0}};
      wdata_reg <= 16'h0000;
      sub_reg <= 2'h0;
      o_cpu_done <= 1'b0;
      o_cpu_rdata <= 16'h0000;
      o_system_config_reg <= {`EBC_SYSCFG_W{1'b0}};
      o_illegal_bus_access_flag <= 1'b0;
      o_class_b_trap <= 1'b0;
      o_shared_addr_data_port <= 16'h0000;
      o_shared_addr_data_oe <= 16'h0000;
      o_demux_address_port <= 16'h0000;
      o_upper_address_port <= 8'h00;
      o_ale <= 1'b0;
      o_read_strobe_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_write_high_strobe_n <= 1'b1;
      o_window_chip_select_n <= {NWIN{1'b1}};
      o_default_chip_select_n <= 1'b1;
      o_bus_request_out_n <= 1'b1;
      o_hold_acknowledge_n <= 1'b1;
      o_hold_acknowledge_oe <= 1'b0;
      init_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      o_cpu_done <= 1'b0;
      o_class_b_trap <= 1'b0;
      init_reg <= 1'b0;
      // first edge after release: latch straps from shared port
      if (init_reg)
        o_system_config_reg <= i_shared_addr_data_port;
      // role of the acknowledge pin
      o_hold_acknowledge_oe <= i_arbitration_enable_bit & ~slave;
      o_hold_acknowledge_n <= ~(state_next == ST_HOLD);
      // slave asks the master for the bus
      o_bus_request_out_n <= ~(i_arbitration_enable_bit &
        ((slave && i_cpu_req && !slave_granted) ||
         (!slave && hold_in && i_cpu_req)));
      case (state_reg)
        ST_IDLE: begin
          o_shared_addr_data_oe <= 16'h0000;
          o_window_chip_select_n <= {NWIN{1'b1}};
          o_default_chip_select_n <= 1'b1;
          if (state_next == ST_ADDR) begin
            if (!ext_on) begin
              // single chip: no external access allowed
              state_reg <= ST_IDLE;
              o_cpu_done <= 1'b1;
              o_illegal_bus_access_flag <= 1'b1;
              o_class_b_trap <= 1'b1;
            end else begin
              cfg_reg <= sel_cfg;
              region_reg <= sel_onehot & {(NWIN+1){sel_cs_en}};
              write_reg <= i_cpu_write;
              byte_reg <= i_cpu_byte;
              addr_reg <= i_cpu_addr;
              wdata_reg <= i_cpu_wdata;
              sub_reg <= 2'h0;
              o_ale <= 1'b1;
              o_demux_address_port <= i_cpu_addr[15:0];
              o_shared_addr_data_port <= i_cpu_addr[15:0];
              o_shared_addr_data_oe <= sel_cfg[`EBC_MODE_LSB] ?
                16'hffff : 16'h0000;
              // early select switches together with the latch strobe rise
              if (i_early_chip_select_bit) begin
                o_window_chip_select_n <= ~(sel_onehot[NWIN-1:0] &
                  {NWIN{sel_cs_en}});
                o_default_chip_select_n <= ~(sel_onehot[NWIN] & sel_cs_en);
              end
              case (space)
                `EBC_SPACE_16M: o_upper_address_port <= i_cpu_addr[23:16];
                `EBC_SPACE_1M: o_upper_address_port <= {4'h0, i_cpu_addr[19:16]};
                `EBC_SPACE_256K: o_upper_address_port <= {6'h00, i_cpu_addr[17:16]};
                default: o_upper_address_port <= 8'h00;
              endcase
            end
          end
        end
        ST_ADDR: begin
          sub_reg <= sub_reg + 2'h1;
          // normal select switches half a cpu cycle after the strobe rise
          if (sub_reg == 2'h0) begin
            o_window_chip_select_n <= ~region_reg[NWIN-1:0];
            o_default_chip_select_n <= ~region_reg[NWIN];
          end
          if (state_next != ST_ADDR) begin
            o_ale <= 1'b0;
            wait_reg <= cfg_reg[`EBC_CFG_WAIT_LSB +: `EBC_CFG_WAIT_W];
            tmo_reg <= 8'h00;
            if (write_reg) begin
              o_shared_addr_data_port <= wdata_reg;
              o_shared_addr_data_oe <= wide ? 16'hffff : 16'h00ff;
            end else begin
              o_shared_addr_data_oe <= 16'h0000;
            end
            if (state_next == ST_CMD) begin
              o_read_strobe_n <= write_reg;
              o_write_strobe_n <= ~write_reg;
              o_write_high_strobe_n <= ~(write_reg & wide & ~byte_reg);
            end
          end
        end
        ST_DLY: begin
          o_read_strobe_n <= write_reg;
          o_write_strobe_n <= ~write_reg;
          o_write_high_strobe_n <= ~(write_reg & wide & ~byte_reg);
        end
        ST_CMD: begin
          if (!wait_done)
            wait_reg <= wait_reg - 4'h1;
          if (rdy_en && !rdy_ok)
            tmo_reg <= tmo_reg + 8'h01;
          if (state_next != ST_CMD) begin
            o_read_strobe_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_write_high_strobe_n <= 1'b1;
            o_cpu_done <= 1'b1;
            o_cpu_rdata <= wide ? i_shared_addr_data_port :
              {8'h00, i_shared_addr_data_port[7:0]};
            if (tmo) begin
              o_illegal_bus_access_flag <= 1'b1;
              o_class_b_trap <= 1'b1;
            end
            if (!cfg_reg[`EBC_CFG_TRI_BIT]) begin
              o_window_chip_select_n <= {NWIN{1'b1}};
              o_default_chip_select_n <= 1'b1;
            end
            o_shared_addr_data_oe <= 16'h0000;
          end
        end
        ST_TRI: begin
          o_window_chip_select_n <= {NWIN{1'b1}};
          o_default_chip_select_n <= 1'b1;
        end
        default: begin
          o_shared_addr_data_oe <= 16'h0000;
        end
      endcase
      // clear loses against a new event in the same cycle
      if (i_trap_flag_clear && !trap_set)
        o_illegal_bus_access_flag <= 1'b0;
    end
  end

  wire unused_ok = muxed ^ addr_reg[0];
endmodule // ebc_ctrl

`default_nettype wire

// File: core/ebc_map.vh
/*
  constants for the external bus controller: mode codes, config field
  positions, address space codes and timing counts.
  assumes a 200 MHz cpu clock and active-low chip selects on the pins.
*/
// Summary of operation
// - single-chip mode plus four external modes, muxed or demuxed, 8 or 16 bit
// - demux modes: address on address port, data on shared or low byte port
// - mux modes: address first, then data, on the shared port
// - cycle time, tri-state time, latch strobe length, rw delay programmable
// - four address windows, each with select and bus config registers
// - window 4 overrides 3, window 2 overrides 1 on overlap
// - addresses outside every window use the default bus config
// - five active-low chip selects, four windows plus default
// - ready-enabled window cycles wait until ready reaches active level or the ready wait limit runs out
// - ready active level chosen per window by a polarity bit
// - arbitration enable hands request, acknowledge, hold pins to the controller
// - master role after reset; slave select bit turns acknowledge to input
// - upper address port drives eight, four, two or no lines
// - chip selects change half cycle after strobe rise, or on it if early
// - illegal external access sets its flag and raises a class b trap
// - at reset release latch config from shared port, strobes inactive
`ifndef EBC_MAP_VH
`define EBC_MAP_VH

// bus mode field of a bus config word
`define EBC_MODE_LSB 6
`define EBC_MODE_W 2
`define EBC_MODE_DEMUX8 2'h0
`define EBC_MODE_MUX8 2'h1
`define EBC_MODE_DEMUX16 2'h2
`define EBC_MODE_MUX16 2'h3

// bus config word fields (16 bits)
`define EBC_CFG_W 16
`define EBC_CFG_WAIT_LSB 0
`define EBC_CFG_WAIT_W 4
`define EBC_CFG_TRI_BIT 4
`define EBC_CFG_ALE_BIT 5
`define EBC_CFG_RWDLY_BIT 8
`define EBC_CFG_ACTIVE_BIT 10
`define EBC_CFG_RDYEN_BIT 12
`define EBC_CFG_RDYLVL_BIT 13
`define EBC_CFG_CSEN_BIT 14

// window select word: base in high 12 bits, size code in low 4 bits
`define EBC_SEL_W 16
`define EBC_SEL_SIZE_W 4

// address space code for the upper address port
`define EBC_SPACE_64K 2'h0
`define EBC_SPACE_256K 2'h1
`define EBC_SPACE_1M 2'h2
`define EBC_SPACE_16M 2'h3

// system config latched at reset release from the shared port
`define EBC_SYSCFG_W 16
`define EBC_SYSCFG_MODE_LSB 6
`define EBC_SYSCFG_SPACE_LSB 9
`define EBC_SYSCFG_EXT_BIT 8

// ready wait limit before an access is declared illegal
`define EBC_READY_TIMEOUT 8'hff

`endif

// File: core/ebc_window.v
/*
  one address window decoder: compares an access address with a base and
  a power-of-two size taken from a window select word.
  assumes 24-bit addresses; size code n gives a 4 kbyte * 2^n window.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.vh"

module ebc_window #(
  parameter AW = 24
) (
  // access address
  input wire [AW-1:0] i_addr,
  // window select word and its enable
  input wire [`EBC_SEL_W-1:0] i_select,
  input wire i_enable,
  // match
  output wire o_hit
);
  wire [3:0] size_code;
  wire [AW-1:0] base;
  wire [AW-1:0] mask;

  assign size_code = i_select[`EBC_SEL_SIZE_W-1:0];
  assign base = {i_select[`EBC_SEL_W-1:`EBC_SEL_SIZE_W], 12'h000};
  // ones above the window size bits, zeros within
  assign mask = {AW{1'b1}} << (5'd12 + {1'b0, size_code});
  assign o_hit = i_enable & ((i_addr & mask) == (base & mask));
endmodule // ebc_window

`default_nettype wire

// File: dv/ebc_ctrl_props.sv
/*
  port checker for ebc_ctrl: reset idling, refusal, select timing, roles.
  bound from the bench; every config used there sets cs enable.
*/
`timescale 1ns/1ps
`default_nettype none
module ebc_ctrl_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // inputs
  input wire logic i_cpu_req,
  input wire logic i_early_chip_select_bit,
  input wire logic i_arbiter_slave_select_bit,
  // outputs
  input wire logic o_cpu_done,
  input wire logic [15:0] o_system_config_reg,
  input wire logic o_class_b_trap,
  input wire logic o_ale,
  input wire logic o_read_strobe_n,
  input wire logic o_write_strobe_n,
  input wire logic [3:0] o_window_chip_select_n,
  input wire logic o_default_chip_select_n,
  input wire logic o_hold_acknowledge_oe
);
  // ---------------------------------------------
  // helpers and properties
  // ---------------------------------------------
  wire logic [4:0] cs_on = ~{o_window_chip_select_n, o_default_chip_select_n};
  wire logic st_off = o_read_strobe_n && o_write_strobe_n;
  wire logic idle = !o_ale && st_off;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence cs_after_ale;
    !(|cs_on) ##1 (|cs_on);
  endsequence
  sequence addr_then_strobe;
    st_off ##[1:3] !st_off;
  endsequence
  reset_idle_a: assert property (
    $rose(i_nrst) |-> idle) else $error("strobes active after reset");
  single_chip_a: assert property (
    !o_system_config_reg[8] |-> idle) else $error("pins moved, single chip");
  refuse_trap_a: assert property (
    i_cpu_req && !o_cpu_done && !o_system_config_reg[8]
    |-> ##[1:2] o_class_b_trap) else $error("no trap on refused access");
  cs_onehot_a: assert property (
    $onehot0(cs_on)) else $error("two chip selects active");
  addr_phase_a: assert property (
    $rose(o_ale) |-> addr_then_strobe) else $error("strobe vs latch order");
  cs_early_a: assert property (
    $rose(o_ale) && i_early_chip_select_bit |-> |cs_on)
    else $error("early select late");
  cs_late_a: assert property (
    $rose(o_ale) && !i_early_chip_select_bit |-> cs_after_ale)
    else $error("select not half cycle after latch");
  slave_ack_a: assert property (
    i_arbiter_slave_select_bit && $past(i_arbiter_slave_select_bit)
    |-> !o_hold_acknowledge_oe) else $error("slave drives acknowledge");
endmodule // ebc_ctrl_props
`default_nettype wire

// File: dv/ebc_mem_model.sv
/*
  pin-side memory with a ready line for the ebc_ctrl bench.
  assumes pins sampled on i_clock; address taken while the latch is high.
*/
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
  // clock and mode
  input wire logic i_clock,
  input wire logic i_mux,
  // bus pins
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic i_ale,
  input wire logic i_read_n,
  input wire logic i_write_n,
  input wire logic i_write_high_n,
  // ready behaviour
  input wire logic i_ready_pol,
  input wire logic [3:0] i_ready_delay,
  // answers
  output logic [15:0] o_data,
  output logic o_ready
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0;
  logic [15:0] adr = 16'h0;
  logic [3:0] cnt = 4'h0;
  always @(posedge i_clock) begin
    if (i_ale)
      adr <= i_mux ? i_data : i_addr;
    if (!i_write_n) begin
      mem[adr[7:0]][7:0] <= i_data[7:0];
      if (!i_write_high_n)
        mem[adr[7:0]][15:8] <= i_data[15:8];
    end
    if (i_read_n && i_write_n)
      cnt <= 4'h0;
    else if (cnt != 4'hf)
      cnt <= cnt + 4'h1;
    if (!i_read_n)
      last <= o_data;
  end
  // a released bus shows the inverse of the last driven word
  assign o_data = !i_read_n ? mem[adr[7:0]] : ~last;
  assign o_ready = (cnt >= i_ready_delay) ? i_ready_pol : !i_ready_pol;
endmodule // ebc_mem_model
`default_nettype wire

// File: dv/test_external_bus_controller.sv
/*
  bench for ebc_ctrl: cpu driver, reference store, pin-side memory model.
  assumes ebc_ctrl_props and ebc_mem_model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_controller;
  logic clk = 1'b0, nrst = 1'b0, req = 1'b0, wr = 1'b0, byt = 1'b0;
  logic early = 1'b0, arb = 1'b0, slave = 1'b0, clr = 1'b0, hold_n = 1'b1;
  logic strap_en = 1'b1, mux = 1'b0, pol = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [23:0] addr = 24'h0;
  logic [15:0] wdata = 16'h0, dcfg = 16'h4480, strap = 16'h0;
  logic [63:0] sel = {16'h0283, 16'h0204, 16'h0183, 16'h0104};
  logic [63:0] wcfg = {4{16'h4480}};
  logic [15:0] ref_m [int];
  logic [23:0] wa [5] = '{24'h01c000, 24'h012000, 24'h02c000, 24'h022000,
                          24'h050000};
  logic [4:0] wcs [5] = '{5'h04, 5'h02, 5'h10, 5'h08, 5'h01};
  int miscompares = 0, num_checks = 0;
  wire done, trap, flag, ale, rd_n, wr_n, wrh_n, dcs_n, rdy, hack_n, hack_oe;
  wire [15:0] rdata, sysc, pin_o, pin_oe, dmx, mdl_d;
  wire [3:0] wcs_n;
  wire [7:0] upa;
  wire bus_request_out_n;
  wire [15:0] pin_i = strap_en ? strap : ((pin_oe & pin_o) | (~pin_oe & mdl_d));

  initial forever #2.5 clk = ~clk;

  ebc_ctrl ebc_ctrl_i (
    .i_clock(clk), .i_nrst(nrst), .i_cpu_req(req), .i_cpu_write(wr),
    .i_cpu_byte(byt), .i_cpu_addr(addr), .i_cpu_wdata(wdata),
    .o_cpu_done(done), .o_cpu_rdata(rdata), .i_window_select_reg(sel),
    .i_window_bus_config_reg(wcfg), .i_default_bus_config_reg(dcfg),
    .i_early_chip_select_bit(early), .i_arbitration_enable_bit(arb),
    .i_arbiter_slave_select_bit(slave), .o_system_config_reg(sysc),
    .o_illegal_bus_access_flag(flag), .o_class_b_trap(trap),
    .i_trap_flag_clear(clr), .i_shared_addr_data_port(pin_i),
    .o_shared_addr_data_port(pin_o), .o_shared_addr_data_oe(pin_oe),
    .o_demux_address_port(dmx), .o_upper_address_port(upa),
    .o_ale(ale), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n),
    .o_write_high_strobe_n(wrh_n), .o_window_chip_select_n(wcs_n),
    .o_default_chip_select_n(dcs_n), .i_ready(rdy),
    .i_hold_request_n(hold_n), .o_bus_request_out_n(bus_request_out_n),
    .i_hold_acknowledge_n(hold_n), .o_hold_acknowledge_n(hack_n),
    .o_hold_acknowledge_oe(hack_oe));
  ebc_mem_model ebc_mem_model_i (
    .i_clock(clk), .i_mux(mux), .i_addr(dmx), .i_data(pin_o), .i_ale(ale),
    .i_read_n(rd_n), .i_write_n(wr_n), .i_write_high_n(wrh_n),
    .i_ready_pol(pol), .i_ready_delay(dly), .o_data(mdl_d), .o_ready(rdy));

  // ---------------------------------------------
  // driver tasks and test sequence
  // ---------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic [15:0] s);
    @(posedge clk);
    strap <= s;
    strap_en <= 1'b1;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    strap_en <= 1'b0;
  endtask

  task automatic access(input logic w, input logic b, input logic [23:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic [4:0] cs,
      output int c);
    cs = 5'h0;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    byt <= b;
    addr <= a;
    wdata <= d;
    for (c = 0; c < 600 && done !== 1'b1; c++) begin
      @(posedge clk);
      #1;
      cs = cs | ~{wcs_n, dcs_n};
    end
    q = rdata;
    if (c == 600) begin
      miscompares++;
      summarize();
    end
    @(posedge clk);
    req <= 1'b0;
  endtask

  initial begin
    logic [15:0] q, d, mk;
    logic [4:0] cs;
    logic [23:0] a;
    int m, c;
    m = $urandom(42);
    do_reset(16'h0000);
    chk(sysc, 16'h0000);
    access(1'b0, 1'b0, 24'h000100, 16'h0, q, cs, c);
    chk({11'h0, cs}, 16'h0);
    chk({15'h0, flag}, 16'h1);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    chk({15'h0, flag}, 16'h0);
    $display("test single_chip done");
    do_reset(16'h0700);
    chk(sysc, 16'h0700);
    for (m = 0; m < 4; m++) begin
      @(posedge clk);
      dcfg <= {8'h44, m[1:0], 6'h0};
      mux <= m[0];
      early <= m[1];
      a = {8'h0, 16'($urandom) & 16'hfffe};
      d = 16'($urandom);
      mk = m[1] ? 16'hffff : 16'h00ff;
      ref_m[a] = d & mk;
      access(1'b1, !m[1], a, d, q, cs, c);
      access(1'b0, !m[1], a, 16'h0, q, cs, c);
      chk(q & mk, ref_m[a]);
      chk({11'h0, cs}, 16'h1);
    end
    $display("test bus_modes done");
    @(posedge clk);
    dcfg <= 16'h4480;
    mux <= 1'b0;
    for (m = 0; m < 5; m++) begin
      d = 16'($urandom);
      ref_m[wa[m]] = d;
      access(1'b1, 1'b0, wa[m], d, q, cs, c);
      chk({11'h0, cs}, {11'h0, wcs[m]});
      chk({8'h00, upa}, {8'h00, wa[m][23:16]});
      access(1'b0, 1'b0, wa[m], 16'h0, q, cs, c);
      chk(q, ref_m[wa[m]]);
    end
    $display("test windows done");
    for (m = 0; m < 2; m++) begin
      @(posedge clk);
      pol <= m[0];
      dly <= 4'h5;
      dcfg <= {2'b01, m[0], 5'h14, 8'h80};
      d = 16'($urandom);
      ref_m[24'h000040] = d;
      access(1'b1, 1'b0, 24'h000040, d, q, cs, c);
      access(1'b0, 1'b0, 24'h000040, 16'h0, q, cs, c);
      chk(q, ref_m[24'h000040]);
      chk({15'h0, c >= 7}, 16'h1);
    end
    $display("test ready done");
    // long latch, rw delay, three waits, tri-state: 1+2+1+4 cycles to done, tri-state cycle after it
    @(posedge clk);
    dcfg <= 16'h45b3;
    d = 16'($urandom);
    ref_m[24'h000042] = d;
    access(1'b1, 1'b0, 24'h000042, d, q, cs, c);
    access(1'b0, 1'b0, 24'h000042, 16'h0, q, cs, c);
    chk(q, ref_m[24'h000042]);
    chk(16'(c), 16'h0008);
    $display("test timing done");
    @(posedge clk);
    arb <= 1'b1;
    slave <= 1'b1;
    req <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0, hack_oe}, 16'h0);
    chk({15'h0, bus_request_out_n}, 16'h0);
    @(posedge clk);
    req <= 1'b0;
    slave <= 1'b0;
    hold_n <= 1'b0;
    for (c = 0; c < 50 && hack_n !== 1'b0; c++) begin
      @(posedge clk);
      #1;
    end
    chk({14'h0, hack_n, hack_oe}, 16'h1);
    $display("test arbitration done");
    summarize();
  end
endmodule // test_external_bus_controller

bind ebc_ctrl ebc_ctrl_props ebc_ctrl_props_i (.*);
`default_nettype wire
